// [rtl/smu_pkg.sv]
// Constants, types and bit layout for the status and interrupt mask unit
// Functional notes
// - A set status bit reaches the interrupt whenever its mask bit is zero and no status read is in progress.
// - A set status bit never reaches the interrupt while its mask bit is one.
// - The interrupt drives a reset pin only when the pin function field selects interrupt duty.
// - A further unmasked event while the interrupt is asserted leaves it asserted, glitch free.
// - The interrupt is released once a serial status read is recognized.
// - Status updates arriving during a status read are deferred until the read ends.
// - The interrupt reasserts at the end of an aborted read or after a new unmasked bit set during it.
// - Mask upper byte, MSB first: low, mid, analog supply, done, fifo full, accum full, upper, lower; reset to one.
// - Mask middle byte: analog pin rise 4..1 then fall 4..1, all reset to one.
// - Mask low byte: digital pin rise 4..1 then fall 4..1, all reset to one.
// - A valid write to the reset register returns every register to its default.
// - The register reset happens at the 16th rising serial clock edge of that frame.
// - Status is 24 bits laid out like the mask: monitor and converter, analog pins, digital pins.
// - A completed status read clears all status bits, except supply flags whose condition persists.
// - An edge status bit sets on each detected rising or falling transition of its pin.
`default_nettype none
package smu_pkg;
    localparam int unsigned NUM_FLAGS = 24;
    localparam int unsigned PIN_COUNT = 4;

    // Status and mask bit positions, shared by both registers
    localparam int unsigned BIT_LOW_SUPPLY = 23;
    localparam int unsigned BIT_MID_SUPPLY = 22;
    localparam int unsigned BIT_ANALOG_SUPPLY = 21;
    localparam int unsigned BIT_CONV_DONE = 20;
    localparam int unsigned BIT_FIFO_FULL = 19;
    localparam int unsigned BIT_ACCUM_FULL = 18;
    localparam int unsigned BIT_UPPER_ALARM = 17;
    localparam int unsigned BIT_LOWER_ALARM = 16;
    localparam int unsigned LSB_ANALOG_RISE = 12;
    localparam int unsigned LSB_ANALOG_FALL = 8;
    localparam int unsigned LSB_DIGITAL_RISE = 4;
    localparam int unsigned LSB_DIGITAL_FALL = 0;

    localparam logic [23:0] MASK_RESET = 24'hff_ffff;
    localparam logic [23:0] STATUS_RESET = 24'h00_0000;
    localparam logic [23:0] SUPPLY_FLAGS = 24'he0_0000;

    // Serial frame: address byte, bit 7 set for a read
    localparam int unsigned READ_FLAG_BIT = 7;
    localparam logic [6:0] IDX_STATUS = 7'h01;
    localparam logic [6:0] IDX_MASK = 7'h02;
    localparam logic [6:0] IDX_PUMP_CTRL = 7'h03;
    localparam logic [6:0] IDX_RESET = 7'h04;
    localparam logic [5:0] ADDR_EDGES = 6'h08;
    localparam logic [5:0] SHORT_FRAME_EDGES = 6'h10;
    localparam logic [5:0] LONG_FRAME_EDGES = 6'h20;
    localparam logic [5:0] EDGE_COUNT_MAX = 6'h3f;
    localparam int unsigned CTRL_FN_LSB = 16;

    typedef enum logic [1:0] {
        SMU_FN_BOTH_RESET,
        SMU_FN_ONE_IRQ,
        SMU_FN_TWO_IRQ,
        SMU_FN_BOTH_IRQ
    } smu_pin_fn_t;

    localparam smu_pin_fn_t PIN_FN_RESET = SMU_FN_BOTH_RESET;

    typedef enum logic [2:0] {
        SMU_IDLE,
        SMU_ADDR,
        SMU_READ,
        SMU_WRITE
    } smu_state_t;
endpackage
`default_nettype wire

// [rtl/smu_edge_if.sv]
// Synchronised level and edge strobes of a group of outside inputs
`default_nettype none
interface smu_edge_if #(parameter int W = 1);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// [rtl/smu_pin_edge.sv]
// Two-flop synchroniser with rising and falling edge strobes
`default_nettype none
module smu_pin_edge #(parameter int W = 1) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Outside inputs
    input wire logic [W-1:0] pins,
    // Synchronised result
    smu_edge_if.src eo
);
    logic [W-1:0] sync_a;
    logic [W-1:0] sync_b;
    logic [W-1:0] prev;
    logic [W-1:0] next_sync_a;
    logic [W-1:0] next_sync_b;
    logic [W-1:0] next_prev;

    always_comb begin
        next_sync_a = pins;
        next_sync_b = sync_a;
        next_prev = sync_b;
    end

    // Chain runs through reset, so a pin idling high gives no false edge after it
    always_ff @(posedge clk) begin
        sync_a <= next_sync_a;
        sync_b <= next_sync_b;
        prev <= next_prev;
    end

    // Edges only compare settled stages; none reported while in reset
    assign eo.level = sync_b;
    assign eo.rise = sync_b & ~prev & ~{W{rst}};
    assign eo.fall = ~sync_b & prev & ~{W{rst}};
endmodule
`default_nettype wire

// [rtl/smu_flag_bank.sv]
// Sticky status flags with deferral during a status read
`default_nettype none
module smu_flag_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic hold,
    input wire logic done_ok,
    input wire logic done_abort,
    // Sources
    input wire logic [23:0] events,
    input wire logic [23:0] persist,
    // Result
    output logic [23:0] status
);
    logic [23:0] pending;
    logic [23:0] next_status;
    logic [23:0] next_pending;

    // Events of the closing cycle are kept, so a set always beats the clear
    always_comb begin
        next_status = status;
        next_pending = pending;
        if (clear) begin
            next_status = smu_pkg::STATUS_RESET | events;
            next_pending = smu_pkg::STATUS_RESET;
        end else if (done_ok) begin
            next_status = pending | events | persist;
            next_pending = smu_pkg::STATUS_RESET;
        end else if (done_abort) begin
            next_status = status | pending | events;
            next_pending = smu_pkg::STATUS_RESET;
        end else if (hold) begin
            next_pending = pending | events;
        end else begin
            next_status = status | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status <= smu_pkg::STATUS_RESET;
            pending <= smu_pkg::STATUS_RESET;
        end else begin
            status <= next_status;
            pending <= next_pending;
        end
    end
endmodule
`default_nettype wire

// [rtl/smu_top.sv]
// Status, interrupt mask and soft reset unit behind the serial port
`default_nettype none
module smu_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial port from the host
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Programmable pins
    input wire logic [3:0] analog_side_programmable_pin,
    input wire logic [3:0] logic_side_programmable_pin,
    // Supply monitors, high while the supply is below threshold
    input wire logic low_supply_below,
    input wire logic mid_supply_below,
    input wire logic analog_supply_below,
    // Converter events, one-cycle pulses on clk
    input wire logic conversion_done,
    input wire logic sample_fifo_full,
    input wire logic accumulator_full,
    input wire logic upper_alarm,
    input wire logic lower_alarm,
    // Reset or interrupt pins
    output logic reset_or_irq_pin_one,
    output logic reset_or_irq_pin_two
);
    smu_edge_if #(.W(3)) ser_e ();
    smu_edge_if #(.W(3)) mon_e ();
    smu_edge_if #(.W(4)) ana_e ();
    smu_edge_if #(.W(4)) dig_e ();

    smu_pin_edge #(.W(3)) u_ser (
        .clk(clk),
        .rst(rst),
        .pins({cs_n, sclk, din}),
        .eo(ser_e)
    );
    smu_pin_edge #(.W(3)) u_mon (
        .clk(clk),
        .rst(rst),
        .pins({low_supply_below, mid_supply_below, analog_supply_below}),
        .eo(mon_e)
    );
    smu_pin_edge #(.W(4)) u_ana (
        .clk(clk),
        .rst(rst),
        .pins(analog_side_programmable_pin),
        .eo(ana_e)
    );
    smu_pin_edge #(.W(4)) u_dig (
        .clk(clk),
        .rst(rst),
        .pins(logic_side_programmable_pin),
        .eo(dig_e)
    );

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic din_level;
    assign cs_fall = ser_e.fall[2];
    assign cs_rise = ser_e.rise[2];
    assign sclk_rise = ser_e.rise[1];
    assign sclk_fall = ser_e.fall[1];
    assign din_level = ser_e.level[0];

    // Status sources in register order
    logic [23:0] events;
    logic [23:0] persist;
    logic [23:0] status;
    assign events = {mon_e.level, conversion_done, sample_fifo_full, accumulator_full,
                     upper_alarm, lower_alarm, ana_e.rise, ana_e.fall,
                     dig_e.rise, dig_e.fall};
    assign persist = {mon_e.level, 21'h00_0000} & smu_pkg::SUPPLY_FLAGS;

    // Serial state
    smu_pkg::smu_state_t state;
    smu_pkg::smu_state_t next_state;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit_cnt;
    logic [23:0] shift_in;
    logic [23:0] next_shift_in;
    logic [6:0] addr_idx;
    logic [6:0] next_addr_idx;
    logic [23:0] rd_shadow;
    logic [23:0] next_rd_shadow;
    logic next_dout;
    logic next_dout_oe;
    logic reading;
    logic next_reading;
    logic [23:0] mask;
    logic [23:0] next_mask;
    smu_pkg::smu_pin_fn_t pin_fn;
    smu_pkg::smu_pin_fn_t next_pin_fn;
    logic read_start;
    logic done_ok;
    logic done_abort;
    logic soft_clr;
    logic [23:0] shifted;
    logic [5:0] cnt_inc;

    assign shifted = {shift_in[22:0], din_level};
    assign cnt_inc = (bit_cnt == smu_pkg::EDGE_COUNT_MAX) ? bit_cnt : bit_cnt + 6'h01;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_addr_idx = addr_idx;
        next_rd_shadow = rd_shadow;
        next_dout = dout;
        next_dout_oe = dout_oe;
        next_reading = reading;
        next_mask = mask;
        next_pin_fn = pin_fn;
        read_start = 1'b0;
        done_ok = 1'b0;
        done_abort = 1'b0;
        soft_clr = 1'b0;
        case (state)
            smu_pkg::SMU_IDLE: begin
                if (cs_fall) begin
                    next_state = smu_pkg::SMU_ADDR;
                    next_bit_cnt = '0;
                end
            end
            smu_pkg::SMU_ADDR: begin
                if (sclk_rise) begin
                    next_shift_in = shifted;
                    next_bit_cnt = cnt_inc;
                    if (cnt_inc == smu_pkg::ADDR_EDGES) begin
                        next_addr_idx = shifted[6:0];
                        if (shifted[smu_pkg::READ_FLAG_BIT]) begin
                            next_state = smu_pkg::SMU_READ;
                            next_dout_oe = 1'b1;
                            if (shifted[6:0] == smu_pkg::IDX_STATUS) begin
                                read_start = 1'b1;
                                next_reading = 1'b1;
                                next_rd_shadow = status;
                            end else if (shifted[6:0] == smu_pkg::IDX_MASK) begin
                                next_rd_shadow = mask;
                            end else if (shifted[6:0] == smu_pkg::IDX_PUMP_CTRL) begin
                                next_rd_shadow = 24'(pin_fn) << smu_pkg::CTRL_FN_LSB;
                            end else begin
                                next_rd_shadow = '0;
                            end
                        end else begin
                            next_state = smu_pkg::SMU_WRITE;
                        end
                    end
                end
            end
            smu_pkg::SMU_READ: begin
                if (sclk_rise) begin
                    next_bit_cnt = cnt_inc;
                end
                // Data changes on falling edges, MSB first
                if (sclk_fall) begin
                    next_dout = rd_shadow[23];
                    next_rd_shadow = {rd_shadow[22:0], 1'b0};
                end
            end
            smu_pkg::SMU_WRITE: begin
                if (sclk_rise) begin
                    next_shift_in = shifted;
                    next_bit_cnt = cnt_inc;
                    if (cnt_inc == smu_pkg::SHORT_FRAME_EDGES) begin
                        // Data bits of a reset write are ignored
                        if (addr_idx == smu_pkg::IDX_RESET) begin
                            soft_clr = 1'b1;
                        end else if (addr_idx == smu_pkg::IDX_PUMP_CTRL) begin
                            next_pin_fn = smu_pkg::smu_pin_fn_t'(shifted[1:0]);
                        end
                    end
                    if (cnt_inc == smu_pkg::LONG_FRAME_EDGES &&
                        addr_idx == smu_pkg::IDX_MASK) begin
                        next_mask = shifted;
                    end
                end
            end
            default: begin
                next_state = smu_pkg::SMU_IDLE;
            end
        endcase
        // Frame end wins for state and data out; a write or read start from an edge in the same cycle still takes effect
        if (cs_rise) begin
            next_state = smu_pkg::SMU_IDLE;
            next_dout_oe = 1'b0;
            next_dout = 1'b0;
            if (reading) begin
                next_reading = 1'b0;
                if (bit_cnt >= smu_pkg::LONG_FRAME_EDGES) begin
                    done_ok = 1'b1;
                end else begin
                    done_abort = 1'b1;
                end
            end
        end
        if (soft_clr) begin
            next_mask = smu_pkg::MASK_RESET;
            next_pin_fn = smu_pkg::PIN_FN_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= smu_pkg::SMU_IDLE;
            bit_cnt <= '0;
            shift_in <= '0;
            addr_idx <= '0;
            rd_shadow <= '0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            reading <= 1'b0;
            mask <= smu_pkg::MASK_RESET;
            pin_fn <= smu_pkg::PIN_FN_RESET;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            addr_idx <= next_addr_idx;
            rd_shadow <= next_rd_shadow;
            dout <= next_dout;
            dout_oe <= next_dout_oe;
            reading <= next_reading;
            mask <= next_mask;
            pin_fn <= next_pin_fn;
        end
    end

    smu_flag_bank u_flags (
        .clk(clk),
        .rst(rst),
        .clear(soft_clr),
        .hold(reading | read_start),
        .done_ok(done_ok),
        .done_abort(done_abort),
        .events(events),
        .persist(persist),
        .status(status)
    );

    // Interrupt request and pin drive
    logic irq_req;
    logic next_pin_one;
    logic next_pin_two;
    logic use_one;
    logic use_two;

    assign irq_req = (|(status & ~mask)) & ~reading;

    // In reset duty the pins follow the low supply monitor
    always_comb begin
        use_one = (pin_fn == smu_pkg::SMU_FN_ONE_IRQ) || (pin_fn == smu_pkg::SMU_FN_BOTH_IRQ);
        use_two = (pin_fn == smu_pkg::SMU_FN_TWO_IRQ) || (pin_fn == smu_pkg::SMU_FN_BOTH_IRQ);
        next_pin_one = use_one ? irq_req : mon_e.level[2];
        next_pin_two = use_two ? irq_req : mon_e.level[2];
    end

    // Registered so a further event cannot glitch an asserted pin
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_or_irq_pin_one <= 1'b0;
            reset_or_irq_pin_two <= 1'b0;
        end else begin
            reset_or_irq_pin_one <= next_pin_one;
            reset_or_irq_pin_two <= next_pin_two;
        end
    end
endmodule
`default_nettype wire

// [sim/smu_host_model.sv]
// Serial host model that drives frames into the status unit
`default_nettype none
module smu_host_model (
    // Serial port
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // Address byte then nd data bits; a short frame aborts
    task automatic xfer(input logic [7:0] addr, input logic [23:0] wd, input int nd,
            output logic [23:0] rd);
        logic [31:0] sh;
        sh = {addr, wd};
        rd = 24'h00_0000;
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < 8 + nd; i++) begin
            sclk = 1'b0;
            din = sh[31-i];
            #100;
            sclk = 1'b1;
            // Sample late in the high phase, after the shift has settled
            #90;
            if (i >= 8) begin
                rd = {rd[22:0], dout};
            end
            #10;
        end
        sclk = 1'b0;
        #100;
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        din = ~din;
        #200;
    endtask
endmodule
`default_nettype wire

// [sim/smu_monitor.sv]
// Concurrent checks on the serial port and the reset or interrupt pins
`default_nettype none
module smu_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    // Supply and pins
    input wire logic low_supply_below,
    input wire logic reset_or_irq_pin_one,
    input wire logic reset_or_irq_pin_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] sc, cs;
    logic [1:0] ds;
    logic [7:0] adr, next_adr;
    logic [5:0] nr, next_nr;
    logic stat_rd, rd_frame, soft_hit;
    // Own frame decode, never ahead of the design's
    assign stat_rd = !cs[1] && nr >= 6'h08 && adr == 8'h81;
    assign rd_frame = !cs[1] && nr >= 6'h08 && adr[7] && adr[6:0] != 7'h00 && adr[6:0] < 7'h04;
    assign soft_hit = !cs[1] && nr == 6'h10 && adr == 8'h04;
    always_comb begin
        next_nr = nr;
        next_adr = adr;
        if (rst || cs[1]) begin
            next_nr = 6'h00;
        end else if (sc[1] && !sc[2]) begin
            next_nr = nr + 6'h01;
            if (nr < 6'h08) begin
                next_adr = {adr[6:0], ds[1]};
            end
        end
    end
    always_ff @(posedge clk) begin
        sc <= {sc[1:0], sclk};
        cs <= {cs[1:0], cs_n};
        ds <= {ds[0], din};
        nr <= next_nr;
        adr <= next_adr;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_stat_rd;
        (stat_rd && !low_supply_below)[*6];
    endsequence
    sequence s_soft;
        $rose(soft_hit) ##4 1'b1;
    endsequence
    oe_idle_a: assert property (cs_n[*5] |-> !dout_oe)
        else $error("output enable while deselected");
    dout_quiet_a: assert property (!dout_oe && !$past(dout_oe) |-> !dout)
        else $error("data out not low while idle");
    dout_shift_a: assert property ($changed(dout) |-> !sc[1] && !sc[2])
        else $error("data out moved while serial clock high");
    oe_read_a: assert property (rd_frame[*6] |-> dout_oe)
        else $error("no output enable in read data phase");
    irq_release_a: assert property (s_stat_rd |-> !reset_or_irq_pin_one && !reset_or_irq_pin_two)
        else $error("interrupt held during status read");
    irq_hold_a: assert property (cs == 3'b111 && reset_or_irq_pin_one |=> reset_or_irq_pin_one)
        else $error("interrupt dropped without a frame");
    duty_reset_a: assert property ($fell(rst) |-> (reset_or_irq_pin_one == reset_or_irq_pin_two)[*4])
        else $error("pins differ in reset duty");
    soft_reset_a: assert property (s_soft |-> (reset_or_irq_pin_one == reset_or_irq_pin_two)[*4])
        else $error("soft reset left interrupt duty");
endmodule
bind smu_top smu_monitor i_smu_monitor (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .low_supply_below(low_supply_below), .reset_or_irq_pin_one(reset_or_irq_pin_one),
    .reset_or_irq_pin_two(reset_or_irq_pin_two)
);
`default_nettype wire

// [sim/tb_smu_top.sv]
// Self-checking bench for the status and interrupt mask unit
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_smu_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sclk, din, dout, dout_oe, pin1, pin2;
    logic [3:0] apin = 4'h0;
    logic [3:0] dpin = 4'h0;
    logic [2:0] sup = 3'h0;
    logic [4:0] ev = 5'h00;
    logic [23:0] r;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    smu_top i_smu_top (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .analog_side_programmable_pin(apin),
        .logic_side_programmable_pin(dpin), .low_supply_below(sup[2]),
        .mid_supply_below(sup[1]), .analog_supply_below(sup[0]), .conversion_done(ev[4]),
        .sample_fifo_full(ev[3]), .accumulator_full(ev[2]), .upper_alarm(ev[1]),
        .lower_alarm(ev[0]), .reset_or_irq_pin_one(pin1), .reset_or_irq_pin_two(pin2));
    smu_host_model i_smu_host_model (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Whole run is about 7.4k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic wait_n(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic xf(input logic [7:0] a, input logic [23:0] d, input int n);
        i_smu_host_model.xfer(a, d, n, r);
        wait_n(1);
    endtask
    task automatic rd(input logic [6:0] i, input int n);
        xf({1'b1, i}, 24'h00_0000, n);
    endtask
    task automatic wr(input logic [6:0] i, input logic [23:0] d, input int n);
        xf({1'b0, i}, d, n);
    endtask
    task automatic ctl(input logic [1:0] c);
        wr(smu_pkg::IDX_PUMP_CTRL, {6'h00, c, 16'h0000}, 8);
    endtask
    task automatic pulse(input logic [4:0] e);
        ev = e;
        wait_n(1);
        ev = 5'h00;
        wait_n(4);
    endtask
    initial begin
        wait_n(3);
        rst = 1'b0;
        wait_n(6);
        rd(smu_pkg::IDX_MASK, 24);
        `CHK(r, 24'hff_ffff)
        `CHK(dout_oe, 1'b0)
        rd(smu_pkg::IDX_PUMP_CTRL, 8);
        `CHK(r[1:0], 2'b00)
        ctl(2'b11);
        pulse(5'b10000);
        `CHK({pin1, pin2}, 2'b00)
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h10_0000)
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h00_0000)
        wr(smu_pkg::IDX_MASK, 24'hef_ffff, 24);
        rd(smu_pkg::IDX_MASK, 24);
        `CHK(r, 24'hef_ffff)
        pulse(5'b10000);
        `CHK({pin1, pin2}, 2'b11)
        pulse(5'b10000);
        `CHK({pin1, pin2}, 2'b11)
        for (int c = 0; c < 4; c++) begin
            ctl(2'(c));
            `CHK({pin1, pin2}, {c[0], c[1]})
            rd(smu_pkg::IDX_PUMP_CTRL, 8);
            `CHK(r[1:0], 2'(c))
        end
        // Unmasked and masked events land in mid read
        fork
            rd(smu_pkg::IDX_STATUS, 24);
            begin
                #2000;
                `CHK({pin1, pin2}, 2'b00)
                `CHK(dout_oe, 1'b1)
                pulse(5'b11000);
            end
        join
        `CHK(r, 24'h10_0000)
        `CHK({pin1, pin2}, 2'b11)
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h18_0000)
        `CHK({pin1, pin2}, 2'b00)
        pulse(5'b10000);
        rd(smu_pkg::IDX_STATUS, 8);
        `CHK(r[7:0], 8'h10)
        `CHK({pin1, pin2}, 2'b11)
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h10_0000)
        apin = 4'h1;
        wait_n(4);
        apin = 4'h0;
        dpin = 4'h8;
        pulse(5'b01111);
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h0f_1180)
        sup = 3'h7;
        wait_n(4);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
                sup = 3'h0;
            end
            rd(smu_pkg::IDX_STATUS, 24);
            `CHK(r, (k < 3) ? 24'he0_0000 : 24'h00_0000)
        end
        wr(7'h7f, 24'h12_3456, 24);
        rd(7'h7f, 24);
        `CHK(r, 24'h00_0000)
        wr(smu_pkg::IDX_MASK, 24'h00_0000, 24);
        ctl(2'b01);
        pulse(5'b00001);
        `CHK({pin1, pin2}, 2'b10)
        // One edge short of a reset write
        wr(smu_pkg::IDX_RESET, 24'h00_0000, 7);
        rd(smu_pkg::IDX_MASK, 24);
        `CHK(r, 24'h00_0000)
        wr(smu_pkg::IDX_RESET, 24'ha5_0000, 8);
        `CHK({pin1, pin2}, 2'b00)
        rd(smu_pkg::IDX_MASK, 24);
        `CHK(r, 24'hff_ffff)
        rd(smu_pkg::IDX_PUMP_CTRL, 8);
        `CHK(r[1:0], 2'b00)
        rd(smu_pkg::IDX_STATUS, 24);
        `CHK(r, 24'h00_0000)
        conclude();
    end
endmodule
`default_nettype wire
